// File: hw/zfa_pkg.sv
/*
 * Package for the zero-flag and attenuation-mode register bank:
 * register indices, field positions, reset values, timing counts and carriers.
 * Assumes a 10 MHz system clock and 16-bit control-port words.
 */
package zfa_pkg;

	localparam int unsigned ZFA_CLK_HZ = 10_000_000;

	// Register indices as carried in the index field of a control word
	localparam logic [6:0] ZFA_IDX_RESET_CTRL = 7'h0A;
	localparam logic [6:0] ZFA_IDX_ATTEN_FLAG_CONFIG = 7'h0D;
	localparam logic [6:0] ZFA_IDX_CHANNEL_SILENCE_STATUS = 7'h0E;

	// Field positions in the data byte
	localparam int unsigned ZFA_BIT_SOFT_REINIT = 7;
	localparam int unsigned ZFA_BIT_FLAG_POLARITY = 6;
	localparam int unsigned ZFA_BIT_ATTEN_STEP_MODE = 7;
	localparam int unsigned ZFA_FLD_GROUP_HI = 6;
	localparam int unsigned ZFA_FLD_GROUP_LO = 5;

	// Reset values
	localparam logic ZFA_RST_ATTEN_STEP_MODE = 1'b0;
	localparam logic ZFA_RST_FLAG_POLARITY = 1'b0;
	localparam logic [1:0] ZFA_RST_FLAG_GROUP = 2'h0;

	// Flag-group codes
	localparam logic [1:0] ZFA_GRP_LEFT_RIGHT = 2'h0;
	localparam logic [1:0] ZFA_GRP_ALL_LINES = 2'h1;
	localparam logic [1:0] ZFA_GRP_LINE4_REST = 2'h2;
	localparam logic [1:0] ZFA_GRP_LINE1_REST = 2'h3;

	// Attenuation step sizes (half-dB units) and floors (dB below full scale)
	localparam logic [1:0] ZFA_STEP_FINE_HALF_DB = 2'h1;
	localparam logic [1:0] ZFA_STEP_WIDE_HALF_DB = 2'h2;
	localparam logic [6:0] ZFA_FLOOR_FINE_DB = 7'h3F;
	localparam logic [6:0] ZFA_FLOOR_WIDE_DB = 7'h64;

	// Soft reinitialisation period in system clocks
	localparam int unsigned ZFA_SOFT_REINIT_CLKS = 1024;
	localparam logic [10:0] ZFA_SOFT_REINIT_LAST = 11'(ZFA_SOFT_REINIT_CLKS - 1);

	// Consecutive all-zero samples before a channel counts as silent
	localparam int unsigned ZFA_ZERO_RUN_SAMPLES = 1024;
	localparam logic [10:0] ZFA_ZERO_RUN_LAST = 11'(ZFA_ZERO_RUN_SAMPLES - 1);

	localparam int unsigned ZFA_NUM_CH = 8;

	// One control-port word: B15 read flag, B14..B8 index, B7..B0 data
	typedef struct packed {
		logic rd;
		logic [6:0] index;
		logic [7:0] data;
	} zfa_ctl_word_t;

	// Attenuation configuration handed to the attenuator
	typedef struct packed {
		logic step_mode;
		logic [1:0] step_half_db;
		logic [6:0] floor_db;
	} zfa_atten_cfg_t;

endpackage

// File: hw/zfa_regs.sv
/*
 * Register bank for attenuation step mode, zero-flag routing and per-channel
 * silence status. Words arrive already deserialised from the control port on
 * the system clock; sample-zero indications come from same-clock logic.
 */
// Behaviour
// - Mode bit clear (reset) gives half-dB attenuation steps down to -63 dB.
// - Mode bit set gives one-dB attenuation steps down to -100 dB.
// - Group code 0 puts line 1 left on flag pin A and line 1 right on flag pin B.
// - Group code 1 leaves pin A unused and puts all four lines on pin B.
// - Group code 2 puts line 4 on pin A and lines 1 to 3 on pin B.
// - Group code 3 puts line 1 on pin A and lines 2 to 4 on pin B.
// - Eight read-only status bits, one per channel, in the low byte, readable only over I2C.
// - A status bit reads one in the zero state regardless of pin polarity.
// - Polarity bit clear drives pins high on detection, set drives them low.
// - The soft reinit bit resets all registers like power-on, holding them through the start cycle and 1024 more clocks.
`timescale 1ns/1ns

module zfa_regs
	import zfa_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ctl_valid,
	input wire zfa_ctl_word_t i_ctl_word,
	input wire logic i_ctl_is_i2c,
	input wire logic i_sample_strobe,
	input wire logic [ZFA_NUM_CH-1:0] i_sample_zero,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data,
	output zfa_atten_cfg_t o_atten_cfg,
	output logic o_silence_flag_pin_a,
	output logic o_silence_flag_pin_b,
	output logic o_reinit_busy
);

	////////////////////////////////////////////////////////////////////////////
	// Soft reinitialisation

	logic reinit_busy_q;
	logic [10:0] reinit_cnt_q;
	logic atten_step_mode_q;
	logic [1:0] flag_group_select_q;
	logic flag_pin_polarity_q;

	wire logic wr_take = i_ctl_valid && !i_ctl_word.rd && !reinit_busy_q;
	wire logic rd_take = i_ctl_valid && i_ctl_word.rd && !reinit_busy_q;
	wire logic wr_reset_ctrl = wr_take && (i_ctl_word.index == ZFA_IDX_RESET_CTRL);
	wire logic wr_config = wr_take && (i_ctl_word.index == ZFA_IDX_ATTEN_FLAG_CONFIG);
	wire logic reinit_start = wr_reset_ctrl && i_ctl_word.data[ZFA_BIT_SOFT_REINIT];
	wire logic reinit_hold = reinit_start || reinit_busy_q;

	// Start edge is held as well; busy output stands one cycle past the count
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reinit_busy_q <= 1'b0;
			reinit_cnt_q <= '0;
		end else if (reinit_start) begin
			reinit_busy_q <= 1'b1;
			reinit_cnt_q <= '0;
		end else if (reinit_busy_q) begin
			reinit_busy_q <= (reinit_cnt_q != ZFA_SOFT_REINIT_LAST);
			reinit_cnt_q <= reinit_cnt_q + 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Writable configuration

	wire logic cfg_mode_in = i_ctl_word.data[ZFA_BIT_ATTEN_STEP_MODE];
	wire logic [1:0] cfg_group_in = i_ctl_word.data[ZFA_FLD_GROUP_HI:ZFA_FLD_GROUP_LO];
	wire logic polarity_in = i_ctl_word.data[ZFA_BIT_FLAG_POLARITY];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			atten_step_mode_q <= ZFA_RST_ATTEN_STEP_MODE;
			flag_group_select_q <= ZFA_RST_FLAG_GROUP;
		end else if (reinit_hold) begin
			atten_step_mode_q <= ZFA_RST_ATTEN_STEP_MODE;
			flag_group_select_q <= ZFA_RST_FLAG_GROUP;
		end else if (wr_config) begin
			atten_step_mode_q <= cfg_mode_in;
			flag_group_select_q <= cfg_group_in;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_pin_polarity_q <= ZFA_RST_FLAG_POLARITY;
		end else if (reinit_hold) begin
			flag_pin_polarity_q <= ZFA_RST_FLAG_POLARITY;
		end else if (wr_reset_ctrl) begin
			flag_pin_polarity_q <= polarity_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel zero detection

	logic [ZFA_NUM_CH-1:0] silent_q;

	for (genvar ch = 0; ch < ZFA_NUM_CH; ch++) begin : g_zero
		// Run counter stops at the last count once silent
		logic [10:0] run_q;
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				run_q <= '0;
				silent_q[ch] <= 1'b0;
			end else if (reinit_hold) begin
				run_q <= '0;
				silent_q[ch] <= 1'b0;
			end else if (i_sample_strobe) begin
				if (!i_sample_zero[ch]) begin
					run_q <= '0;
					silent_q[ch] <= 1'b0;
				end else if (run_q == ZFA_ZERO_RUN_LAST) begin
					silent_q[ch] <= 1'b1;
				end else begin
					run_q <= run_q + 11'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag routing; channels 2k and 2k+1 are left and right of line k+1

	wire logic [3:0] line_silent = {&silent_q[7:6], &silent_q[5:4], &silent_q[3:2], &silent_q[1:0]};
	logic grp_a;
	logic grp_a_used;
	logic grp_b;

	always_comb begin
		grp_a = 1'b0;
		grp_a_used = 1'b1;
		grp_b = 1'b0;
		unique case (flag_group_select_q)
			ZFA_GRP_LEFT_RIGHT: begin
				grp_a = silent_q[0];
				grp_b = silent_q[1];
			end
			ZFA_GRP_ALL_LINES: begin
				grp_a_used = 1'b0;
				grp_b = &line_silent;
			end
			ZFA_GRP_LINE4_REST: begin
				grp_a = line_silent[3];
				grp_b = &line_silent[2:0];
			end
			ZFA_GRP_LINE1_REST: begin
				grp_a = line_silent[0];
				grp_b = &line_silent[3:1];
			end
		endcase
	end

	wire logic pin_a_d = (grp_a && grp_a_used) ^ flag_pin_polarity_q;
	wire logic pin_b_d = grp_b ^ flag_pin_polarity_q;

	////////////////////////////////////////////////////////////////////////////
	// Read-back and outputs

	wire logic status_hit = rd_take && i_ctl_is_i2c &&
		(i_ctl_word.index == ZFA_IDX_CHANNEL_SILENCE_STATUS);
	wire logic config_hit = rd_take && (i_ctl_word.index == ZFA_IDX_ATTEN_FLAG_CONFIG);
	wire logic reset_hit = rd_take && (i_ctl_word.index == ZFA_IDX_RESET_CTRL);
	wire logic [7:0] config_byte = {atten_step_mode_q, flag_group_select_q, 5'h00};
	wire logic [7:0] reset_byte = {1'b0, flag_pin_polarity_q, 6'h00};
	wire logic [7:0] rd_byte = status_hit ? silent_q :
		config_hit ? config_byte :
		reset_hit ? reset_byte : 8'h00;
	// Fixed step settings handed to the attenuator
	localparam zfa_atten_cfg_t ATTEN_FINE = '{
		step_mode: 1'b0,
		step_half_db: ZFA_STEP_FINE_HALF_DB,
		floor_db: ZFA_FLOOR_FINE_DB
	};
	localparam zfa_atten_cfg_t ATTEN_WIDE = '{
		step_mode: 1'b1,
		step_half_db: ZFA_STEP_WIDE_HALF_DB,
		floor_db: ZFA_FLOOR_WIDE_DB
	};
	wire zfa_atten_cfg_t atten_d = atten_step_mode_q ? ATTEN_WIDE : ATTEN_FINE;
	wire logic [15:0] rd_word = rd_take ? {1'b0, i_ctl_word.index, rd_byte} : 16'h0000;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			o_rd_valid <= rd_take;
			o_rd_data <= rd_word;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_atten_cfg <= ATTEN_FINE;
		end else begin
			o_atten_cfg <= atten_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_silence_flag_pin_a <= ZFA_RST_FLAG_POLARITY;
			o_silence_flag_pin_b <= ZFA_RST_FLAG_POLARITY;
		end else begin
			o_silence_flag_pin_a <= pin_a_d;
			o_silence_flag_pin_b <= pin_b_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reinit_busy <= 1'b0;
		end else begin
			o_reinit_busy <= reinit_hold;
		end
	end

endmodule

// File: bench/zfa_host.sv
/* Host model driving control words into zfa_regs.
   Assumes the bench calls xfer from one process only. */
`timescale 1ns/1ns
module zfa_host import zfa_pkg::*; (
	input wire logic i_clk,
	input wire logic [15:0] i_rd_data,
	output logic o_valid,
	output zfa_ctl_word_t o_word,
	output logic o_is_i2c
);
	logic [15:0] last_q;
	initial begin
		o_valid = 1'b0;
		o_word = '0;
		o_is_i2c = 1'b0;
	end
	// One word; released word shows its inverse
	task automatic xfer(input zfa_ctl_word_t w, input logic i2c);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_word <= w;
		o_is_i2c <= i2c;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_word <= ~w;
		#1;
		last_q = i_rd_data;
	endtask
endmodule

// File: bench/zfa_regs_chk.sv
/* Concurrent checks on zfa_regs ports.
   Bound to every zfa_regs instance. */
`timescale 1ns/1ns
module zfa_regs_chk import zfa_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ctl_valid,
	input wire zfa_ctl_word_t i_ctl_word,
	input wire logic i_ctl_is_i2c,
	input wire logic o_rd_valid,
	input wire logic [15:0] o_rd_data,
	input wire zfa_atten_cfg_t o_atten_cfg,
	input wire logic o_silence_flag_pin_a,
	input wire logic o_silence_flag_pin_b,
	input wire logic o_reinit_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [10:0] busy_n_q;
	// Last busy cycle already takes words again
	wire logic take_rd = i_ctl_valid && i_ctl_word.rd && !(o_reinit_busy && busy_n_q != 11'h400);
	wire logic [6:0] idx = i_ctl_word.index;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			busy_n_q <= 11'h000;
		else
			busy_n_q <= o_reinit_busy ? busy_n_q + 11'h001 : 11'h000;
	end
	fine_cfg_a: assert property (!o_atten_cfg.step_mode |-> o_atten_cfg == 10'h0BF)
		else $error("fine step setting wrong");
	wide_cfg_a: assert property (o_atten_cfg.step_mode |-> o_atten_cfg == 10'h364)
		else $error("wide step setting wrong");
	rd_answer_a: assert property (take_rd |=> o_rd_valid && o_rd_data[15:8] == {1'b0, $past(idx)})
		else $error("read answer missing");
	no_answer_a: assert property (!take_rd |=> !o_rd_valid)
		else $error("read answer without request");
	spi_status_a: assert property (take_rd && idx == 7'h0E && !i_ctl_is_i2c |=> o_rd_data[7:0] == 8'h00)
		else $error("status visible off I2C");
	busy_len_a: assert property ($fell(o_reinit_busy) |-> busy_n_q == 11'h401)
		else $error("reinit length wrong");
	busy_max_a: assert property (busy_n_q <= 11'h401)
		else $error("reinit too long");
	reinit_dflt_a: assert property (o_reinit_busy && $past(o_reinit_busy) |-> o_atten_cfg == 10'h0BF &&
		!o_silence_flag_pin_a && !o_silence_flag_pin_b)
		else $error("defaults not held in reinit");
	cover property (o_rd_valid);
	cover property ($rose(o_reinit_busy));
	cover property ($rose(o_silence_flag_pin_b));
endmodule
bind zfa_regs zfa_regs_chk u_chk (.i_clk, .i_rst_n, .i_ctl_valid, .i_ctl_word, .i_ctl_is_i2c, .o_rd_valid,
	.o_rd_data, .o_atten_cfg, .o_silence_flag_pin_a, .o_silence_flag_pin_b, .o_reinit_busy);

// File: bench/zfa_regs_tb_top.sv
/* Self-checking bench for zfa_regs.
   Host model drives words; samples are driven here. */
`timescale 1ns/1ns
module zfa_regs_tb_top import zfa_pkg::*; ;
	localparam logic [3:0] A_RAW = 4'h9;
	localparam logic [3:0] B_RAW = 4'h5;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic strb = 1'b0;
	logic [7:0] zero = 8'h00;
	logic vld, i2c, rv, pa, pb, busy;
	zfa_ctl_word_t word;
	logic [15:0] rdat;
	zfa_atten_cfg_t cfg;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	initial forever #50 i_clk = ~i_clk;
	zfa_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ctl_valid(vld), .i_ctl_word(word), .i_ctl_is_i2c(i2c),
		.i_sample_strobe(strb), .i_sample_zero(zero), .o_rd_valid(rv), .o_rd_data(rdat), .o_atten_cfg(cfg),
		.o_silence_flag_pin_a(pa), .o_silence_flag_pin_b(pb), .o_reinit_busy(busy));
	zfa_host host (.i_clk(i_clk), .i_rd_data(rdat), .o_valid(vld), .o_word(word), .o_is_i2c(i2c));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, 1'b1);
		@(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic c, input logic [15:0] exp);
		host.xfer({1'b1, a, 8'h00}, c);
		chk("read", host.last_q, exp);
	endtask
	task automatic strobes(input int n, input logic [7:0] z);
		repeat (n) begin
			@(posedge i_clk);
			strb <= 1'b1;
			zero <= z;
			@(posedge i_clk);
			strb <= 1'b0;
		end
		#1;
	endtask
	task automatic t_mode();
		rd(7'h0D, 1'b1, 16'h0D00);
		rd(7'h7F, 1'b1, 16'h7F00);
		chk("cfg", 16'(cfg), 16'h00BF);
		wr(7'h0D, 8'h80);
		chk("cfg", 16'(cfg), 16'h0364);
		rd(7'h0D, 1'b1, 16'h0D80);
	endtask
	task automatic t_silence();
		strobes(1023, 8'h3F);
		rd(7'h0E, 1'b1, 16'h0E00);
		strobes(1, 8'h3F);
		rd(7'h0E, 1'b1, 16'h0E3F);
		rd(7'h0E, 1'b0, 16'h0E00);
		for (int p = 0; p < 2; p++) begin
			wr(7'h0A, 8'({p[0], 6'h00}));
			rd(7'h0E, 1'b1, 16'h0E3F);
			for (int g = 0; g < 4; g++) begin
				wr(7'h0D, 8'(g << 5));
				chk("pin_a", 16'(pa), 16'(A_RAW[g] ^ p[0]));
				chk("pin_b", 16'(pb), 16'(B_RAW[g] ^ p[0]));
			end
		end
		strobes(1, 8'h3E);
		rd(7'h0E, 1'b1, 16'h0E3E);
	endtask
	task automatic t_reinit();
		int n;
		n = 0;
		wr(7'h0D, 8'hE0);
		wr(7'h0A, 8'h40);
		rd(7'h0A, 1'b1, 16'h0A40);
		chk("cfg", 16'(cfg), 16'h0364);
		wr(7'h0A, 8'h80);
		chk("busy", 16'(busy), 16'h0001);
		while (busy === 1'b1 && n < 2000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk("busy_len", 16'(n), 16'h0400);
		chk("cfg", 16'(cfg), 16'h00BF);
		chk("pin_a", 16'(pa), 16'h0000);
		chk("pin_b", 16'(pb), 16'h0000);
		rd(7'h0D, 1'b1, 16'h0D00);
		rd(7'h0A, 1'b1, 16'h0A00);
		rd(7'h0E, 1'b1, 16'h0E00);
	endtask
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_mode();
		t_silence();
		t_reinit();
		final_report();
	end
endmodule
